// File: design/mivec_top.sv
// Interrupt vectoring, source enables, timers, pin and bus event detection.
module mivec_top
   import mivec_pkg::*;
#(
   parameter int TICK_CYC = T128_CYC,       // cycles per 128 us tick
   parameter int WAKE_TICKS = WAKE_BASE_TICKS // 1.024 ms ticks per wake period unit
) (
   input wire logic clk_sys,                // system clock
   input wire logic rst_b,                  // async reset, active low
   input wire mivec_apb_req_type apb_req,   // APB request
   output mivec_apb_rsp_type apb_rsp,       // APB response
   input wire logic [9:0] gpio_pin,         // general-purpose pins, async
   input wire logic usb_dp,                 // USB D+ pin, async
   input wire logic usb_dm,                 // USB D- pin, async
   input wire logic ps2_serial_data_pin,    // PS2 data pin, async
   input wire logic ep0_event,              // control_endpoint_zero event pulse
   input wire logic ep1_event,              // second_endpoint event pulse
   input wire logic part_awake,             // part is not suspended
   input wire logic cpu_gie,                // CPU global interrupt enable
   input wire logic cpu_instr_done,         // instruction boundary pulse
   output logic cpu_gie_clear,              // pulse: clear CPU global enable
   output logic irq_request,                // an enabled request is pending
   output logic cpu_call,                   // automatic call in progress
   output logic service_start,              // pulse: first service_routine fetch
   output logic [15:0] fetch_addr,          // vector address being called
   output logic usb_addr_clear,             // hold USB device address cleared
   output logic bus_event_seen              // sticky bus event status
);
   // ****************************************************
   // registers and synchronisers
   // ****************************************************
   logic [7:0] global_en_q, ep_en_q, p0_en_q, p1_en_q, p0_pol_q, p1_pol_q;
   logic [7:0] mode_q, wake_q;
   logic [VEC_COUNT:1] pend_q;
   logic [VEC_COUNT:1] pend_set, pend_clr, pend_en;
   logic [12:0] pin_s1_q, pin_s2_q;
   logic [9:0] gpio_s, pin_en, pin_pol, trig_now, trig_prev_q;
   logic dp_s, dm_s, ps2_s;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= {ps2_serial_data_pin, usb_dm, usb_dp, gpio_pin};
         pin_s2_q <= pin_s1_q;
      end
   end
   assign gpio_s = pin_s2_q[9:0];
   assign dp_s = pin_s2_q[10];
   assign dm_s = pin_s2_q[11];
   assign ps2_s = pin_s2_q[12];

   // ****************************************************
   // APB slave
   // ****************************************************
   logic setup, wr_en;
   logic [7:0] idx;
   logic [31:0] rd_mux, prdata_q;
   logic mapped, mapped_q;

   assign setup = apb_req.psel & ~apb_req.penable;
   assign idx = apb_req.paddr[9:2];
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & mapped;

   always_comb begin
      rd_mux = '0;
      mapped = (apb_req.paddr[11:10] == 2'b00);
      unique case (idx)
         IDX_GLOBAL_EN: rd_mux[7:0] = global_en_q & 8'hC7;
         IDX_EP_EN: rd_mux[7:0] = ep_en_q;
         IDX_P0_EN: rd_mux[7:0] = p0_en_q;
         IDX_P1_EN: rd_mux[7:0] = {6'h00, p1_en_q[1:0]};
         IDX_P0_POL: rd_mux[7:0] = p0_pol_q;
         IDX_P1_POL: rd_mux[7:0] = {6'h00, p1_pol_q[1:0]};
         IDX_PENDING: rd_mux[15:0] = {3'h0, bus_event_seen, pend_q, 1'b0};
         IDX_MODE: rd_mux[7:0] = mode_q;
         IDX_WAKE: rd_mux[7:0] = wake_q;
         default: mapped = 1'b0;
      endcase
   end

   // read data is captured in the setup cycle so it leaves a flip-flop
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prdata_q <= '0;
         mapped_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
         mapped_q <= mapped;
      end
   end

   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped_q;
   assign apb_rsp.prdata = prdata_q;

   logic wake_write;
   assign wake_write = wr_en & (idx == IDX_GLOBAL_EN);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         global_en_q <= GLOBAL_EN_RST;
         ep_en_q <= EP_EN_RST;
         p0_en_q <= PIN_EN_RST; // [RL10]
         p1_en_q <= PIN_EN_RST; // [RL10]
         p0_pol_q <= PIN_POL_RST; // [RL12]
         p1_pol_q <= PIN_POL_RST; // [RL12]
         mode_q <= MODE_RST;
         wake_q <= WAKE_RST;
      end else if (wr_en) begin
         unique case (idx)
            IDX_GLOBAL_EN: global_en_q <= apb_req.pwdata[7:0] & 8'hC7;
            IDX_EP_EN: ep_en_q <= apb_req.pwdata[7:0] & EE_MASK;
            IDX_P0_EN: p0_en_q <= apb_req.pwdata[7:0];
            IDX_P1_EN: p1_en_q <= {6'h00, apb_req.pwdata[1:0]};
            IDX_P0_POL: p0_pol_q <= apb_req.pwdata[7:0];
            IDX_P1_POL: p1_pol_q <= {6'h00, apb_req.pwdata[1:0]};
            IDX_MODE: mode_q <= {7'h00, apb_req.pwdata[0]};
            IDX_WAKE: wake_q <= apb_req.pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ****************************************************
   // free-running timer
   // ****************************************************
   logic [15:0] tick_cnt_q;
   logic [2:0] tick8_q;
   logic tick128, tick1024;

   assign tick128 = (tick_cnt_q == 16'(TICK_CYC - 1));
   assign tick1024 = tick128 & (tick8_q == 3'(TICKS_PER_1024 - 1));

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_q <= '0;
         tick8_q <= '0;
      end else begin
         tick_cnt_q <= tick128 ? 16'h0000 : tick_cnt_q + 16'h0001;
         if (tick128) begin
            tick8_q <= tick8_q + 3'h1;
         end
      end
   end

   // ****************************************************
   // wake-up timer
   // ****************************************************
   logic [15:0] wake_cnt_q;
   logic [15:0] wake_limit;
   logic wake_fire;

   // period is (wake_q + 1) base units, so periods come in whole multiples
   assign wake_limit = 16'((32'(wake_q) + 32'h1) * 32'(WAKE_TICKS) - 32'h1);
   assign wake_fire = global_en_q[GE_WAKE] & tick1024 & (wake_cnt_q == wake_limit);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wake_cnt_q <= '0;
      end else if (wake_write && !apb_req.pwdata[GE_WAKE]) begin
         wake_cnt_q <= '0; // [RL8]
      end else if (global_en_q[GE_WAKE] && tick1024) begin
         wake_cnt_q <= wake_fire ? 16'h0000 : wake_cnt_q + 16'h0001; // [RL8]
      end
   end

   // ****************************************************
   // bus reset / PS2 activity detection
   // ****************************************************
   logic bus_cond, bus_det_q, bus_cond_q, bus_fire, bus_seen_q;
   logic [1:0] bus_ticks_q;

   // selected condition, chosen by the mode bit
   assign bus_cond = mode_q[MODE_PS2] ? ~ps2_s : (~dp_s & ~dm_s); // [RL18] [RL19] [RL20]

   // two ticks of persistence land between 128 and 256 us from the start
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus_ticks_q <= '0;
         bus_det_q <= 1'b0;
         bus_cond_q <= 1'b0;
      end else begin
         bus_cond_q <= bus_cond;
         if (!bus_cond) begin
            bus_ticks_q <= '0;
         end else if (tick128 && bus_ticks_q != 2'(BUS_DET_TICKS)) begin
            bus_ticks_q <= bus_ticks_q + 2'h1; // [RL18]
         end
         if (bus_cond && tick128 && bus_ticks_q == 2'(BUS_DET_TICKS - 1)) begin
            bus_det_q <= 1'b1;
         end else if (!bus_cond && !mode_q[MODE_PS2]) begin
            bus_det_q <= 1'b0;
         end else if (!bus_cond) begin
            bus_det_q <= 1'b0;
         end
      end
   end

   // PS2 fires on detection; USB fires when the long SE0 ends
   assign bus_fire = mode_q[MODE_PS2]
      ? (bus_cond && tick128 && bus_ticks_q == 2'(BUS_DET_TICKS - 1)) // [RL20]
      : (bus_det_q & ~bus_cond & bus_cond_q); // [RL19] [RL22]

   assign usb_addr_clear = bus_cond & (bus_det_q | (bus_ticks_q != 2'h0)); // [RL21]

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bus_seen_q <= 1'b0;
      end else if (bus_fire) begin
         bus_seen_q <= 1'b1;
      end else if (wr_en && idx == IDX_PENDING && apb_req.pwdata[15]) begin
         bus_seen_q <= 1'b0;
      end
   end
   assign bus_event_seen = bus_seen_q;

   // ****************************************************
   // general-purpose pin interrupts
   // ****************************************************
   logic lock_q;
   logic [3:0] lock_pin_q;
   logic [9:0] pin_edge;
   logic gpio_fire, lock_release;
   logic [3:0] first_pin;

   assign pin_en = {p1_en_q[1:0], p0_en_q};
   assign pin_pol = {p1_pol_q[1:0], p0_pol_q};

   genvar g;
   generate
      for (g = 0; g < 10; g++) begin : g_pin
         assign trig_now[g] = ~(gpio_s[g] ^ pin_pol[g]); // [RL12]
         assign pin_edge[g] = trig_now[g] & ~trig_prev_q[g] & pin_en[g]; // [RL11]
      end
   endgenerate

   // pins are equal peers: an edge fires unless the locked pin still triggers, the lowest index is tracked
   always_comb begin
      first_pin = 4'h0;
      for (int i = 9; i >= 0; i--) begin
         if (pin_edge[i]) begin
            first_pin = 4'(i); // [RL14]
         end
      end
   end

   assign lock_release = ~trig_now[lock_pin_q] | ~pin_en[lock_pin_q]; // [RL13]
   assign gpio_fire = (|pin_edge) & (~lock_q | lock_release); // [RL13]

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trig_prev_q <= '1;
         lock_q <= 1'b0;
         lock_pin_q <= '0;
      end else begin
         trig_prev_q <= trig_now;
         if (gpio_fire) begin
            lock_q <= 1'b1; // [RL13]
            lock_pin_q <= first_pin;
         end else if (lock_q && lock_release) begin
            lock_q <= 1'b0; // [RL13]
         end
      end
   end

   // ****************************************************
   // pending flags and priority
   // ****************************************************
   mivec_ack_state_type state_q;
   logic gie_clear_q;
   logic [3:0] best_num, serve_num_q, cnt_q;
   logic any_req;

   always_comb begin
      pend_set = '0;
      pend_set[VEC_BUS] = bus_fire;
      pend_set[VEC_T128] = tick128; // [RL16]
      pend_set[VEC_T1024] = tick1024; // [RL15]
      pend_set[VEC_EP0] = ep0_event;
      pend_set[VEC_EP1] = ep1_event;
      pend_set[VEC_GPIO] = gpio_fire; // [RL6]
      pend_set[VEC_WAKE] = wake_fire & part_awake; // [RL9]
      pend_en = '0;
      pend_en[VEC_BUS] = global_en_q[GE_BUS];
      pend_en[VEC_T128] = global_en_q[GE_T128]; // [RL16]
      pend_en[VEC_T1024] = global_en_q[GE_T1024]; // [RL15]
      pend_en[VEC_EP0] = ep_en_q[EE_EP0];
      pend_en[VEC_EP1] = |ep_en_q[2:1];
      pend_en[VEC_GPIO] = global_en_q[GE_GPIO]; // [RL11]
      pend_en[VEC_WAKE] = global_en_q[GE_WAKE];
      pend_clr = '0;
      // flag clears only after the cycle that clears the core enable
      if (state_q == ST_CLR_PEND && !gie_clear_q) begin
         pend_clr[serve_num_q] = 1'b1; // [RL24]
      end
   end

   // set wins over clear; vectors 6 to 9 never get a source
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~pend_clr) | pend_set; // [RL5]
      end
   end

   always_comb begin
      best_num = 4'h0;
      for (int v = VEC_COUNT; v >= 1; v--) begin
         if (pend_q[v] && pend_en[v]) begin
            best_num = 4'(v); // [RL1] [RL23]
         end
      end
   end
   assign any_req = |(pend_q & pend_en); // [RL23]
   assign irq_request = any_req;

   // ****************************************************
   // acknowledge sequence
   // ****************************************************
   logic start_q;
   logic [15:0] fetch_q;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         serve_num_q <= '0;
         cnt_q <= '0;
         gie_clear_q <= 1'b0;
         start_q <= 1'b0;
         fetch_q <= RESET_FETCH; // [RL2]
      end else begin
         gie_clear_q <= 1'b0;
         start_q <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (cpu_instr_done && cpu_gie && any_req) begin
                  gie_clear_q <= 1'b1; // [RL24] [RL23]
                  serve_num_q <= best_num;
                  state_q <= ST_CLR_PEND;
               end
            end
            ST_CLR_PEND: begin
               if (!gie_clear_q) begin
                  // slot address is the number times the slot width
                  fetch_q <= 16'(32'(serve_num_q) * VEC_SLOT_BYTES); // [RL3] [RL4] [RL5] [RL6]
                  cnt_q <= CALL_CYC - 4'h1; // [RL7]
                  state_q <= ST_CALL; // [RL24]
               end
            end
            ST_CALL: begin
               if (cnt_q == 4'h0) begin
                  cnt_q <= JMP_CYC - 4'h1; // [RL7]
                  state_q <= ST_JMP;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            ST_JMP: begin
               if (cnt_q == 4'h0) begin
                  start_q <= 1'b1; // [RL7]
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
         endcase
      end
   end

   assign cpu_gie_clear = gie_clear_q;
   assign cpu_call = (state_q == ST_CALL);
   assign service_start = start_q;
   assign fetch_addr = fetch_q;
endmodule

// File: design/mivec_pkg.sv
// Package of constants and carrier types for the interrupt vectoring block.
// Notes on behaviour
// RL1: fixed priority by vector number; bus-reset/PS2 is 1 highest, wake-up 11 lowest.
// RL2: after reset the fetch address is program address zero, not an interrupt.
// RL3: vector slots are two bytes; address is vector number times two.
// RL4: bus-reset/PS2 at 0x0002, 128 us timer 0x0004, 1.024 ms timer 0x0006.
// RL5: control endpoint 0x0008, second endpoint 0x000A; vectors 6 to 9 unused.
// RL6: all general-purpose pins share one vector at 0x0014.
// RL7: latency is remaining instruction cycles plus ten call plus five jump cycles; here two clear cycles also come before the call.
// RL8: writing wake-up enable zero clears and stops the timer; one runs it.
// RL9: wake-up timer raises periodic interrupts while enabled and awake.
// RL10: reset clears every per-pin interrupt enable register.
// RL11: pin interrupt needs its own enable and the global pin enable.
// RL12: per-pin polarity, zero falling, one rising; polarity resets to zero.
// RL13: after one pin triggers, others locked out until it releases or disables.
// RL14: no priority among pins; acknowledge leaves pin enables untouched.
// RL15: free-running timer raises an interrupt every 1.024 ms when enabled.
// RL16: free-running timer raises an interrupt every 128 us when enabled.
// RL17: firmware should disable both timer interrupts before requesting suspend.
// RL18: bus source picked by mode bit; raised after condition lasts 128 to 256 us.
// RL19: USB mode detects SE0 on both lines; interrupt when SE0 ends.
// RL20: PS2 mode detects long low on serial data; interrupt once detected.
// RL21: USB device address held cleared throughout a bus-reset or PS2 event.
// RL22: bus interrupt may come up to 128 us after the condition is removed.
// RL23: pending source requests only if enabled; best one taken at instruction end.
// RL24: acknowledge clears CPU enable, then the pending flag, then calls the vector.
package mivec_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_GLOBAL_EN = 8'h20;
   localparam logic [7:0] IDX_EP_EN = 8'h21;
   localparam logic [7:0] IDX_P0_EN = 8'h04;
   localparam logic [7:0] IDX_P1_EN = 8'h05;
   localparam logic [7:0] IDX_P0_POL = 8'h06;
   localparam logic [7:0] IDX_P1_POL = 8'h07;
   localparam logic [7:0] IDX_PENDING = 8'h30;
   localparam logic [7:0] IDX_MODE = 8'h31;
   localparam logic [7:0] IDX_WAKE = 8'h32;
   // global enable field positions
   localparam int GE_BUS = 0;
   localparam int GE_T128 = 1;
   localparam int GE_T1024 = 2;
   localparam int GE_GPIO = 6;
   localparam int GE_WAKE = 7;
   // endpoint enable fields and writable mask
   localparam int EE_EP0 = 0;
   localparam logic [7:0] EE_MASK = 8'h07;
   // mode register: bit 0 selects PS2 detection
   localparam int MODE_PS2 = 0;
   // reset values
   localparam logic [7:0] GLOBAL_EN_RST = 8'h00;
   localparam logic [7:0] EP_EN_RST = 8'h00;
   localparam logic [7:0] PIN_EN_RST = 8'h00;
   localparam logic [7:0] PIN_POL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] WAKE_RST = 8'h00;
   localparam logic [15:0] RESET_FETCH = 16'h0000;
   // vector numbers
   localparam logic [3:0] VEC_BUS = 4'h1;
   localparam logic [3:0] VEC_T128 = 4'h2;
   localparam logic [3:0] VEC_T1024 = 4'h3;
   localparam logic [3:0] VEC_EP0 = 4'h4;
   localparam logic [3:0] VEC_EP1 = 4'h5;
   localparam logic [3:0] VEC_GPIO = 4'hA;
   localparam logic [3:0] VEC_WAKE = 4'hB;
   localparam int VEC_COUNT = 11;
   localparam int VEC_SLOT_BYTES = 2;
   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int T128_NS = 128_000;
   localparam int T128_CYC = T128_NS / CLK_NS;
   localparam int TICKS_PER_1024 = 8;
   localparam int BUS_DET_TICKS = 2;
   localparam logic [3:0] CALL_CYC = 4'hA;
   localparam logic [3:0] JMP_CYC = 4'h5;
   localparam int WAKE_BASE_TICKS = 32;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } mivec_apb_req_type;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } mivec_apb_rsp_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CLR_PEND = 2'b01,
      ST_CALL = 2'b11,
      ST_JMP = 2'b10
   } mivec_ack_state_type;
endpackage

// File: dv/mivec_asserts.sv
// Checker of the acknowledge sequence, vector addresses and bus answers.
module mivec_asserts
   import mivec_pkg::*;
(
   input wire logic clk_sys,                // clock
   input wire logic rst_b,                  // async reset, active low
   input wire mivec_apb_req_type apb_req,   // bus request
   input wire mivec_apb_rsp_type apb_rsp,   // bus answer
   input wire logic cpu_gie,                // core enable
   input wire logic cpu_instr_done,         // boundary pulse
   input wire logic cpu_gie_clear,          // enable clear pulse
   input wire logic irq_request,            // request level
   input wire logic cpu_call,               // call phase
   input wire logic service_start,          // first service fetch
   input wire logic [15:0] fetch_addr       // vector address
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************
   // sequence tracking
   // ***********************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   logic [4:0] seq_q;
   logic [4:0] seq_d;
   logic called_q;
   logic take;
   // a new take is legal again in the service_start cycle
   assign take = cpu_instr_done && cpu_gie && irq_request && (seq_q == 5'h0 || seq_q == 5'h12);
   always_comb begin
      seq_d = seq_q;
      if (take) begin
         seq_d = 5'h1;
      end else if (seq_q != 5'h0) begin
         seq_d = (seq_q == 5'h12) ? 5'h0 : seq_q + 5'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         seq_q <= 5'h0;
         called_q <= 1'b0;
      end else begin
         seq_q <= seq_d;
         called_q <= called_q | cpu_call;
      end
   end
   sequence s_take;
      take;
   endsequence
   sequence s_call;
      cpu_call[*5] ##1 cpu_call[*5];
   endsequence
   sequence s_jump;
      (!cpu_call && !service_start)[*5];
   endsequence
   chk_ack_order: assert property (s_take |-> ##1 cpu_gie_clear ##1
      (!cpu_gie_clear && !cpu_call) ##1 s_call) else $error("acknowledge order wrong");
   chk_call_jump: assert property (s_take ##3 s_call |-> ##1 s_jump ##1 service_start)
      else $error("service start not after ten call and five jump cycles");
   chk_clear_cause: assert property (cpu_gie_clear |-> $past(take))
      else $error("enable cleared without an acknowledge");
   chk_start_gap: assert property (service_start |-> $past(cpu_call, 6) && !$past(cpu_call, 5))
      else $error("service start spacing wrong");
   chk_vec_range: assert property ($rose(cpu_call) |-> fetch_addr[0] == 1'b0 &&
      fetch_addr >= 16'h0002 && fetch_addr <= 16'h0016 && !(fetch_addr inside {[16'h000C:16'h0012]}))
      else $error("vector address outside the table");
   chk_addr_hold: assert property (cpu_call && $past(cpu_call) |-> $stable(fetch_addr))
      else $error("vector address moved during call");
   chk_reset_fetch: assert property (!called_q && !cpu_call |-> fetch_addr == RESET_FETCH)
      else $error("fetch address not zero after reset");
   chk_apb_ready: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready)
      else $error("no ready in access phase");
   chk_apb_err: assert property (apb_req.psel && apb_req.penable && apb_req.paddr[11:10] != 2'h0
      |-> apb_rsp.pslverr) else $error("unmapped access not refused");
endmodule

bind mivec_top mivec_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .cpu_gie(cpu_gie), .cpu_instr_done(cpu_instr_done),
   .cpu_gie_clear(cpu_gie_clear), .irq_request(irq_request), .cpu_call(cpu_call),
   .service_start(service_start), .fetch_addr(fetch_addr));

// File: dv/mivec_cpu_model.sv
// Behavioural core that ends instructions and owns the global enable.
module mivec_cpu_model (
   input wire logic clk_sys,          // clock
   input wire logic rst_b,            // async reset, active low
   input wire logic ei,               // pulse: enable interrupts
   input wire logic cpu_gie_clear,    // pulse: clear enable
   output logic cpu_gie,              // enable level
   output logic cpu_instr_done        // boundary pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************
   // instruction boundaries and enable
   // ***********************************
   logic [1:0] cnt_q;
   // four-cycle instructions, so a request waits up to three cycles
   assign cpu_instr_done = (cnt_q == 2'h3);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 2'h0;
         cpu_gie <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         cpu_gie <= ei ? 1'b1 : (cpu_gie_clear ? 1'b0 : cpu_gie);
      end
   end
endmodule

// File: dv/tb.sv
// Testbench: register access, source vectoring and bus event detection.
module tb
   import mivec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************
   // environment
   // ***********************************
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   mivec_apb_req_type req = '0;
   mivec_apb_rsp_type rsp;
   logic [9:0] gpio = 10'h0FF;
   logic dp = 1'b1;
   logic dm = 1'b0;
   logic ps2 = 1'b1;
   logic ep0 = 1'b0;
   logic ep1 = 1'b0;
   logic awake = 1'b1;
   logic ei = 1'b0;
   logic gie, done, gclr, irq, call, sstart, aclr, bseen;
   logic [15:0] faddr;
   logic [31:0] rd;
   logic err;
   int fails = 0;
   int num_checks = 0;
   always #20 clk_sys = ~clk_sys;
   mivec_top #(.TICK_CYC(8), .WAKE_TICKS(1)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
      .apb_req(req), .apb_rsp(rsp), .gpio_pin(gpio), .usb_dp(dp), .usb_dm(dm),
      .ps2_serial_data_pin(ps2), .ep0_event(ep0), .ep1_event(ep1), .part_awake(awake),
      .cpu_gie(gie), .cpu_instr_done(done), .cpu_gie_clear(gclr), .irq_request(irq),
      .cpu_call(call), .service_start(sstart), .fetch_addr(faddr), .usb_addr_clear(aclr),
      .bus_event_seen(bseen));
   mivec_cpu_model u_cpu (.clk_sys(clk_sys), .rst_b(rst_b), .ei(ei), .cpu_gie_clear(gclr),
      .cpu_gie(gie), .cpu_instr_done(done));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, w, a, wd};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         print_verdict();
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic rdbit(input logic [11:0] a, input int b, input logic e);
      apb(1'b0, a, 32'h0);
      check({31'h0, rd[b]}, {31'h0, e});
   endtask
   // enable the core, then compare the vector taken
   task automatic serve(input logic [15:0] exp);
      int n;
      ei <= 1'b1;
      @(posedge clk_sys);
      ei <= 1'b0;
      n = 0;
      while (call !== 1'b1 && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
      check({16'h0, faddr}, {16'h0, exp});
      while (sstart !== 1'b1 && n < 240) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 240) begin
         fails++;
         print_verdict();
      end
   endtask
   initial begin
      repeat (50000) @(posedge clk_sys);
      fails++;
      print_verdict();
   end
   // ***********************************
   // scenarios
   // ***********************************
   initial begin
      ticks(8);
      rst_b <= 1'b1;
      rdc(12'h080, 32'h0);
      rdc(12'h084, 32'h0);
      rdc(12'h010, 32'h0);
      rdc(12'h014, 32'h0);
      rdc(12'h018, 32'h0);
      rdc(12'h01C, 32'h0);
      check({16'h0, faddr}, {16'h0, RESET_FETCH});
      apb(1'b1, 12'h080, 32'hFF);
      rdc(12'h080, 32'hC7);
      apb(1'b1, 12'h080, 32'h0);
      apb(1'b1, 12'h084, 32'hFF);
      rdc(12'h084, 32'h07);
      apb(1'b0, 12'h800, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b1, 12'h0C4, 32'h1);
      ps2 <= 1'b0;
      ticks(30);
      check({31'h0, aclr}, 32'h1);
      rdbit(12'h0C0, 1, 1'b1);
      ps2 <= 1'b1;
      ticks(20);
      check({31'h0, aclr}, 32'h0);
      ep0 <= 1'b1;
      ep1 <= 1'b1;
      ticks(1);
      ep0 <= 1'b0;
      ep1 <= 1'b0;
      apb(1'b1, 12'h010, 32'h1);
      gpio[0] <= 1'b0;
      apb(1'b1, 12'h0C8, 32'h0);
      apb(1'b1, 12'h084, 32'h3);
      apb(1'b1, 12'h080, 32'hC1);
      serve(16'h0002);
      serve(16'h0008);
      serve(16'h000A);
      serve(16'h0014);
      serve(16'h0016);
      rdc(12'h010, 32'h1);
      apb(1'b1, 12'h014, 32'h1);
      apb(1'b1, 12'h01C, 32'h1);
      gpio[8] <= 1'b1;
      ticks(4);
      rdbit(12'h0C0, 10, 1'b0);
      gpio[0] <= 1'b1;
      gpio[8] <= 1'b0;
      ticks(4);
      gpio[8] <= 1'b1;
      ticks(4);
      rdbit(12'h0C0, 10, 1'b1);
      apb(1'b1, 12'h080, 32'h0);
      awake <= 1'b0;
      ticks(4);
      awake <= 1'b1;
      apb(1'b1, 12'h080, 32'h04);
      serve(16'h0006);
      apb(1'b1, 12'h080, 32'h02);
      serve(16'h0004);
      apb(1'b1, 12'h080, 32'h06);
      serve(16'h0004);
      apb(1'b1, 12'h080, 32'h0);
      apb(1'b1, 12'h0C0, 32'h8000);
      ticks(1);
      check({31'h0, bseen}, 32'h0);
      apb(1'b1, 12'h0C4, 32'h0);
      dp <= 1'b0;
      ticks(30);
      rdbit(12'h0C0, 1, 1'b0);
      dp <= 1'b1;
      ticks(20);
      rdbit(12'h0C0, 1, 1'b1);
      check({31'h0, bseen}, 32'h1);
      apb(1'b1, 12'h080, 32'h01);
      serve(16'h0002);
      print_verdict();
   end
endmodule
